// file: src/pec_pkg.sv
package pec_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] PEC_RISE_OFS   = 8'h00;
    localparam logic [7:0] PEC_FALL_OFS   = 8'h04;
    localparam logic [7:0] PEC_FLAGS_OFS  = 8'h08;
    localparam logic [7:0] PEC_CTRL_OFS   = 8'h0C;
    localparam logic [7:0] PEC_ANSEL_OFS  = 8'h10;
    localparam logic [7:0] PEC_STATUS_OFS = 8'h14;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int          PEC_PINS        = 6;
    localparam int          PEC_CTRL_MEN    = 0;
    localparam int          PEC_STAT_SUM    = 0;
    localparam int          PEC_STAT_IRQ    = 1;
    localparam logic [5:0]  PEC_EN_RST      = 6'h00;
    localparam logic [5:0]  PEC_FLAG_RST    = 6'h00;
    localparam logic [5:0]  PEC_ANSEL_RST   = 6'h00;
    localparam logic [1:0]  PEC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PEC_RESP_SLVERR = 2'h2;

    // write request held until both channels are in
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } pec_wreq_t;

endpackage

// file: src/pec_top.sv
// What this block does
// - A change interrupt leaves the block only while the master enable is set.
// - Edge detection and flag setting go on with the master enable clear.
// - Every one of the six pins has its own rising and falling detector.
// - A set bit 5..0 of the rising enable register arms rising detection.
// - A set bit 5..0 of the falling enable register arms falling detection.
// - Both enables set on a pin detect edges of either polarity.
// - A pin flag is set on an enabled rising or enabled falling edge.
// - The summary flag is the OR of the six pin flags and is read-only.
// - Writing zero to a pin flag clears it; only hardware sets flags.
// - An enabled edge during a flag write leaves that flag set.
// - An enabled edge wakes the core from sleep when the master is set.
// - A flag from an edge in sleep is set before the first wake cycle.
// - Enables and flags reset to zero, and bits 7 and 6 read as zero.
// - A pin selected as analog reads as a constant zero to the detectors.
`timescale 1ns/1ps
`default_nettype none

module pec_top
    import pec_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    // port pins
    input  wire logic [5:0]  port_pin_in,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid_in,
    output var  logic        s_axi_awready_out,
    input  wire logic [7:0]  s_axi_awaddr_in,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid_in,
    output var  logic        s_axi_wready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    // axi4-lite write response
    output var  logic        s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    output var  logic [1:0]  s_axi_bresp_out,
    // axi4-lite read address
    input  wire logic        s_axi_arvalid_in,
    output var  logic        s_axi_arready_out,
    input  wire logic [7:0]  s_axi_araddr_in,
    // axi4-lite read data
    output var  logic        s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output var  logic [31:0] s_axi_rdata_out,
    output var  logic [1:0]  s_axi_rresp_out,
    // core side
    output var  logic        irq_out,
    output var  logic        wake_out
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // known register offsets
    function automatic logic pec_mapped(input logic [7:0] a);
        pec_mapped = (a == PEC_RISE_OFS) || (a == PEC_FALL_OFS) ||
                     (a == PEC_FLAGS_OFS) || (a == PEC_CTRL_OFS) ||
                     (a == PEC_ANSEL_OFS) || (a == PEC_STATUS_OFS);
    endfunction

    // ------------------------------------------------------------------
    // pin synchroniser and edge detect
    // ------------------------------------------------------------------
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic [5:0] prev_q;
    logic [5:0] ansel_q;
    logic [5:0] pin_dig;
    logic [5:0] rise_pulse;
    logic [5:0] fall_pulse;

    // two flops; the first one is read by nothing else
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= port_pin_in;
            sync2_q <= sync1_q;
        end
    end

    // analog pins look like a steady zero
    assign pin_dig = sync2_q & ~ansel_q;

    // last sample, kept apart from the synchroniser
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev_q <= 6'h00;
        end else begin
            prev_q <= pin_dig;
        end
    end

    // per-pin detectors, one pulse per edge
    assign rise_pulse = pin_dig & ~prev_q;
    assign fall_pulse = ~pin_dig & prev_q;

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    logic       aw_q;
    logic       w_q;
    pec_wreq_t  wreq_q;
    logic       wr_fire;
    logic       rd_fire;

    // one write at a time: address and data may arrive in either order
    assign wr_fire = aw_q && w_q && !s_axi_bvalid_out;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_q              <= 1'b0;
            w_q               <= 1'b0;
            wreq_q            <= '0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= PEC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_q              <= 1'b1;
                wreq_q.addr       <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_q              <= 1'b1;
                wreq_q.data      <= s_axi_wdata_in;
                wreq_q.strb      <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                aw_q             <= 1'b0;
                w_q              <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= pec_mapped(wreq_q.addr) ?
                                    PEC_RESP_OKAY : PEC_RESP_SLVERR;
            end
            // reopen address and data only once the response is taken
            if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    // write strobe per register, only the low byte lane carries data
    logic       wr_lane0;
    logic [5:0] wbits;
    assign wr_lane0 = wr_fire && wreq_q.strb[0];
    assign wbits    = wreq_q.data[5:0];

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [5:0] rise_edge_enable_q;
    logic [5:0] fall_edge_enable_q;
    logic       change_irq_master_enable_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rise_edge_enable_q         <= PEC_EN_RST;
            fall_edge_enable_q         <= PEC_EN_RST;
            change_irq_master_enable_q <= 1'b0;
            ansel_q                    <= PEC_ANSEL_RST;
        end else if (wr_lane0) begin
            unique case (wreq_q.addr)
                PEC_RISE_OFS: rise_edge_enable_q <= wbits;
                PEC_FALL_OFS: fall_edge_enable_q <= wbits;
                PEC_CTRL_OFS: begin
                    change_irq_master_enable_q <= wreq_q.data[PEC_CTRL_MEN];
                end
                PEC_ANSEL_OFS: ansel_q <= wbits;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin change flags
    // ------------------------------------------------------------------
    logic [5:0] pin_change_flag_q;
    logic [5:0] hit;
    logic       flag_wr;

    // either or both polarities may be armed per pin
    assign hit = (rise_pulse & rise_edge_enable_q)
               | (fall_pulse & fall_edge_enable_q);
    assign flag_wr = wr_lane0 && (wreq_q.addr == PEC_FLAGS_OFS);

    // set wins over a written zero; detection ignores the master enable
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_change_flag_q <= PEC_FLAG_RST;
        end else if (flag_wr) begin
            pin_change_flag_q <= (pin_change_flag_q & wbits) | hit;
        end else begin
            pin_change_flag_q <= pin_change_flag_q | hit;
        end
    end

    // summary flag, no storage of its own
    logic change_irq_summary_flag;
    assign change_irq_summary_flag = |pin_change_flag_q;

    // ------------------------------------------------------------------
    // interrupt and wake outputs
    // ------------------------------------------------------------------
    // registered so the outputs come from flops; one cycle behind the flag
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out  <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            irq_out  <= change_irq_summary_flag &&
                        change_irq_master_enable_q;
            // wake is asserted with the flag already stored
            wake_out <= change_irq_summary_flag &&
                        change_irq_master_enable_q;
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_word;

    // unmapped and reserved bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr_in)
            PEC_RISE_OFS:  rd_word[5:0] = rise_edge_enable_q;
            PEC_FALL_OFS:  rd_word[5:0] = fall_edge_enable_q;
            PEC_FLAGS_OFS: rd_word[5:0] = pin_change_flag_q;
            PEC_CTRL_OFS:  rd_word[PEC_CTRL_MEN] = change_irq_master_enable_q;
            PEC_ANSEL_OFS: rd_word[5:0] = ansel_q;
            PEC_STATUS_OFS: begin
                rd_word[PEC_STAT_SUM] = change_irq_summary_flag;
                rd_word[PEC_STAT_IRQ] = irq_out;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= PEC_RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out  <= 1'b1;
                s_axi_rdata_out   <= rd_word;
                s_axi_rresp_out   <= pec_mapped(s_axi_araddr_in) ?
                                     PEC_RESP_OKAY : PEC_RESP_SLVERR;
            end
            if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out  <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence rise_seen_s;
        rise_pulse != 6'h00 && (rise_pulse & rise_edge_enable_q) != 6'h00;
    endsequence

    master_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !change_irq_master_enable_q |=> !irq_out)
        else $error("irq raised with master enable clear");

    detect_masked_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (!change_irq_master_enable_q && hit != 6'h00) |=>
        ((pin_change_flag_q & $past(hit)) == $past(hit)))
        else $error("flag not set while master clear");

    rise_flag_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        rise_seen_s |=> (pin_change_flag_q != 6'h00))
        else $error("armed rise left no flag");

    fall_flag_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (fall_pulse & fall_edge_enable_q) != 6'h00 |=>
        ((pin_change_flag_q & $past(fall_pulse & fall_edge_enable_q)) != 6'h00))
        else $error("armed fall left no flag");

    unarmed_quiet_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (!flag_wr && hit == 6'h00) |=>
        pin_change_flag_q == $past(pin_change_flag_q))
        else $error("flag changed with no enabled edge");

    summary_or_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (pin_change_flag_q == 6'h00) |=> !irq_out)
        else $error("irq with no flags");

    clear_zero_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (flag_wr && hit == 6'h00) |=>
        pin_change_flag_q == ($past(pin_change_flag_q) & $past(wbits)))
        else $error("flag write did not clear");

    set_wins_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        flag_wr |=> ((pin_change_flag_q & $past(hit)) == $past(hit)))
        else $error("edge lost during flag clear");

    wake_order_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        $rose(wake_out) |-> $past(pin_change_flag_q) != 6'h00)
        else $error("wake before flag stored");

    wake_gate_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (change_irq_summary_flag && change_irq_master_enable_q) |=> wake_out)
        else $error("enabled flag did not wake");

    analog_zero_a: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        ((rise_pulse | fall_pulse) & ansel_q & $past(ansel_q)) == 6'h00)
        else $error("edge seen on analog pin");

endmodule

`default_nettype wire

// file: tb/pec_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module pec_pin_model (
    // clock
    input  wire logic       clk_in,
    // requested and driven pin levels
    input  wire logic [5:0] level_in,
    output var  logic [5:0] port_pin_out
);
    // ------------------------------------------------
    // pin driver
    // ------------------------------------------------
    logic [5:0] drive_q = 6'h00;
    logic [2:0] hold_q  = 3'h0;

    // one driver per signal; the start values sit in the declarations
    assign port_pin_out = drive_q;

    // a level held under two cycles could slip past the synchroniser
    always @(posedge clk_in) begin
        if (level_in != drive_q && hold_q >= 3'h2) begin
            drive_q      <= level_in;
            hold_q       <= 3'h0;
        end else if (hold_q != 3'h7) begin
            hold_q <= hold_q + 3'h1;
        end
    end
endmodule

`default_nettype wire

// file: tb/pin_edge_change_interrupt_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pin_edge_change_interrupt_tb
    import pec_pkg::*;
;
    // ------------------------------------------------
    // signals and expectation model
    // ------------------------------------------------
    logic        clk_in    = 1'b0;
    logic        arst_n_in = 1'b0;
    logic [5:0]  lvl       = 6'h00;
    logic [5:0]  pins;
    logic        awv       = 1'b0;
    logic        wv        = 1'b0;
    logic        bry       = 1'b0;
    logic        arv       = 1'b0;
    logic        rry       = 1'b0;
    logic [7:0]  awa       = 8'h00;
    logic [7:0]  ara       = 8'h00;
    logic [31:0] wd        = 32'h0;
    logic [3:0]  ws        = 4'h0;
    logic        awrdy, wrdy, bv, arrdy, rv, irq, wake;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [1:0]  exp_b[$];
    logic [33:0] exp_r[$];
    logic [5:0]  rise_v, fall_v, ans_v, flg_v, eff_v, pin_v;
    int          failures = 0;
    int          checked  = 0;

    always #10 clk_in = ~clk_in;

    pec_pin_model i_pec_pin_model (
        .clk_in       (clk_in),
        .level_in     (lvl),
        .port_pin_out (pins)
    );

    pec_top i_pec_top (
        .clk_in            (clk_in),
        .arst_n_in         (arst_n_in),
        .port_pin_in       (pins),
        .s_axi_awvalid_in  (awv),
        .s_axi_awready_out (awrdy),
        .s_axi_awaddr_in   (awa),
        .s_axi_wvalid_in   (wv),
        .s_axi_wready_out  (wrdy),
        .s_axi_wdata_in    (wd),
        .s_axi_wstrb_in    (ws),
        .s_axi_bvalid_out  (bv),
        .s_axi_bready_in   (bry),
        .s_axi_bresp_out   (bresp),
        .s_axi_arvalid_in  (arv),
        .s_axi_arready_out (arrdy),
        .s_axi_araddr_in   (ara),
        .s_axi_rvalid_out  (rv),
        .s_axi_rready_in   (rry),
        .s_axi_rdata_out   (rdata),
        .s_axi_rresp_out   (rresp),
        .irq_out           (irq),
        .wake_out          (wake)
    );

    // ------------------------------------------------
    // reporting
    // ------------------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // every wait is bounded; running out counts as a mismatch
    task automatic guard(inout int n);
        n++;
        if (n > 40) begin
            failures++;
            final_report();
        end
    endtask

    // responses are judged here, in the order they were noted
    always @(posedge clk_in) begin
        if (bv && bry) begin
            check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
        end
        if (rv && rry) begin
            check({rresp, rdata}, exp_r.pop_front());
        end
    end

    // ------------------------------------------------
    // bus master
    // ------------------------------------------------
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] st, input logic [1:0] er);
        int n;
        n = 0;
        exp_b.push_back(er);
        awa <= a;
        wd  <= d;
        ws  <= st;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk_in);
            if (awrdy) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            guard(n);
        end while (bv !== 1'b1);
        bry <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int n;
        n = 0;
        exp_r.push_back({er, d});
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk_in);
            if (arrdy) arv <= 1'b0;
            guard(n);
        end while (rv !== 1'b1);
        rry <= 1'b0;
        @(posedge clk_in);
    endtask

    // enabled edges between two effective pin levels
    function automatic logic [5:0] hit(input logic [5:0] o, input logic [5:0] v);
        return (rise_v & ~o & v) | (fall_v & o & ~v);
    endfunction

    task automatic step(input logic [5:0] v);
        flg_v |= hit(eff_v, v);
        eff_v = v;
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        int n;
        int ks [4] = '{1, 2, 3, 6};
        void'($urandom(62189));
        {rise_v, fall_v, ans_v, flg_v, eff_v, pin_v} = '0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        bus_rd(PEC_RISE_OFS, 32'h0, PEC_RESP_OKAY);
        bus_rd(PEC_FALL_OFS, 32'h0, PEC_RESP_OKAY);
        bus_rd(PEC_FLAGS_OFS, 32'h0, PEC_RESP_OKAY);
        bus_rd(8'h18, 32'h0, PEC_RESP_SLVERR);
        bus_wr(8'h18, 32'hFF, 4'hF, PEC_RESP_SLVERR);
        bus_wr(PEC_FALL_OFS, 32'hFFFFFFFF, 4'hF, PEC_RESP_OKAY);
        bus_rd(PEC_FALL_OFS, 32'h3F, PEC_RESP_OKAY);
        bus_wr(PEC_FALL_OFS, 32'h0, 4'h0, PEC_RESP_OKAY);
        bus_rd(PEC_FALL_OFS, 32'h3F, PEC_RESP_OKAY);
        bus_wr(PEC_STATUS_OFS, 32'hFF, 4'hF, PEC_RESP_OKAY);
        bus_rd(PEC_STATUS_OFS, 32'h0, PEC_RESP_OKAY);
        fall_v = 6'h3F;
        // random enables, analog selects and pin levels, master off
        for (int i = 0; i < 40; i++) begin
            rise_v = 6'($urandom);
            fall_v = 6'($urandom);
            ans_v  = (i % 4 == 0) ? 6'($urandom) : 6'h00;
            bus_wr(PEC_RISE_OFS, {26'h0, rise_v}, 4'hF,
                   PEC_RESP_OKAY);
            bus_wr(PEC_FALL_OFS, {26'h0, fall_v}, 4'hF,
                   PEC_RESP_OKAY);
            bus_wr(PEC_ANSEL_OFS, {26'h0, ans_v}, 4'hF,
                   PEC_RESP_OKAY);
            repeat (6) @(posedge clk_in);
            step(pin_v & ~ans_v);
            pin_v = 6'($urandom);
            lvl <= pin_v;
            repeat (8) @(posedge clk_in);
            step(pin_v & ~ans_v);
            bus_rd(PEC_FLAGS_OFS, {26'h0, flg_v},
                   PEC_RESP_OKAY);
            bus_rd(PEC_STATUS_OFS, {31'h0, |flg_v},
                   PEC_RESP_OKAY);
            check({33'h0, irq}, 34'h0);
            // clear only what was seen, so a fresh edge survives
            bus_wr(PEC_FLAGS_OFS, {26'h0, ~flg_v}, 4'hF,
                   PEC_RESP_OKAY);
            flg_v = 6'h00;
        end
        // master enable gates the request and the wake
        rise_v = 6'h3F;
        fall_v = 6'h00;
        bus_wr(PEC_RISE_OFS, 32'h3F, 4'hF, PEC_RESP_OKAY);
        bus_wr(PEC_FALL_OFS, 32'h0, 4'hF, PEC_RESP_OKAY);
        lvl <= 6'h00;
        repeat (8) @(posedge clk_in);
        bus_wr(PEC_FLAGS_OFS, 32'h0, 4'hF, PEC_RESP_OKAY);
        bus_wr(PEC_CTRL_OFS, 32'h1, 4'hF, PEC_RESP_OKAY);
        check({33'h0, irq}, 34'h0);
        lvl <= 6'h01;
        n = 0;
        while (wake !== 1'b1) begin
            @(posedge clk_in);
            guard(n);
        end
        check({33'h0, irq}, 34'h1);
        bus_rd(PEC_FLAGS_OFS, 32'h01, PEC_RESP_OKAY);
        bus_rd(PEC_STATUS_OFS, 32'h3, PEC_RESP_OKAY);
        bus_wr(PEC_CTRL_OFS, 32'h0, 4'hF, PEC_RESP_OKAY);
        repeat (3) @(posedge clk_in);
        check({32'h0, irq, wake}, 34'h0);
        bus_rd(PEC_STATUS_OFS, 32'h1, PEC_RESP_OKAY);
        bus_wr(PEC_FLAGS_OFS, 32'h3E, 4'hF, PEC_RESP_OKAY);
        bus_rd(PEC_FLAGS_OFS, 32'h0, PEC_RESP_OKAY);
        // flag lands 4 edges after the pin and the write 2 after the call:
        // an edge at or after the clearing write survives, an older one not
        foreach (ks[j]) begin
            lvl <= 6'h05;
            repeat (ks[j]) @(posedge clk_in);
            bus_wr(PEC_FLAGS_OFS, 32'h0, 4'hF, PEC_RESP_OKAY);
            bus_rd(PEC_FLAGS_OFS, (ks[j] <= 2) ? 32'h04 : 32'h0,
                   PEC_RESP_OKAY);
            bus_wr(PEC_FLAGS_OFS, 32'h0, 4'hF, PEC_RESP_OKAY);
            lvl <= 6'h01;
            repeat (6) @(posedge clk_in);
        end
        // a second reset in mid-run clears enables and flags
        lvl <= 6'h05;
        repeat (8) @(posedge clk_in);
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        check({32'h0, irq, wake}, 34'h0);
        bus_rd(PEC_RISE_OFS, 32'h0, PEC_RESP_OKAY);
        bus_rd(PEC_FLAGS_OFS, 32'h0, PEC_RESP_OKAY);
        final_report();
    end
endmodule

`default_nettype wire
